// ===== rtl/pqu_regs.svh
// timing counts and widths of the product/quotient unit
`ifndef PQU_REGS_SVH
`define PQU_REGS_SVH
`define PQU_CLK_MHZ 50
`define PQU_NARROW_W 16
`define PQU_DIV_ITERS 6'h20
`define PQU_SKIP_8 6'h17
`define PQU_SKIP_16 6'h0F
`define PQU_SKIP_24 6'h07
`define PQU_DIV_SETUP 6'h00
// skip bits that give the extra fix-up wait of narrow dividends
`define PQU_PAD_HI 4
`define PQU_PAD_LO 3
`define PQU_MUL_GPR_NARROW 2'h2
`define PQU_MUL_GPR_WIDE 2'h3
`define PQU_MUL_ACC_NARROW 2'h1
`define PQU_MUL_ACC_WIDE 2'h2
`endif

// ===== rtl/pqu_pkg.sv
// types of the product/quotient unit
package pqu_pkg;
	typedef enum logic [2:0]
	{
		PQU_OP_WIDENING = 3'h0,
		PQU_OP_ACCUM = 3'h1,
		PQU_OP_SUBTRACT = 3'h2,
		PQU_OP_QUOTIENT = 3'h3,
		PQU_OP_GPR_MUL = 3'h4
	} pqu_op_t;
	typedef enum logic [2:0]
	{
		PQU_ST_IDLE = 3'h1,
		PQU_ST_DIV = 3'h2,
		PQU_ST_FIX = 3'h4
	} pqu_div_state_t;
endpackage

// ===== rtl/pqu_booth_pass.sv
// one 32x16 booth-recoded multiplier pass
`timescale 1ns/1ps
module pqu_booth_pass
(
	// operands
	input wire logic [31:0] multiplicand,
	input wire logic [15:0] multiplier_half,
	input wire logic signed_mult,
	input wire logic signed_half,
	// result
	output logic [63:0] partial
);
	logic [65:0] acc_sum;
	logic [33:0] mcand_ext;
	logic [18:0] mplr_ext;

	// radix-4 recoding over eight digit positions plus a sign/zero digit
	always_comb
	begin
		mcand_ext = {{2{signed_mult & multiplicand[31]}}, multiplicand};
		mplr_ext = {{2{signed_half & multiplier_half[15]}}, multiplier_half, 1'b0};
		acc_sum = 66'h0;
		for (int i = 0; i < 9; i++)
		begin
			logic [2:0] dig;
			logic [65:0] pp;
			dig = mplr_ext[2*i +: 3];
			pp = 66'h0;
			unique case (dig)
				3'h1, 3'h2: pp = {{32{mcand_ext[33]}}, mcand_ext};
				3'h3: pp = {{31{mcand_ext[33]}}, mcand_ext, 1'b0};
				3'h4: pp = 66'h0 - {{31{mcand_ext[33]}}, mcand_ext, 1'b0};
				3'h5, 3'h6: pp = 66'h0 - {{32{mcand_ext[33]}}, mcand_ext};
				default: pp = 66'h0;
			endcase
			acc_sum = acc_sum + (pp << (2 * i));
		end
		partial = acc_sum[63:0];
	end
endmodule

// ===== rtl/pqu_core.sv
// product/quotient unit: multiply array, divider, interlock
`timescale 1ns/1ps
`include "pqu_regs.svh"

// What this block does
// - own pipeline keeps advancing during integer stalls
// - booth array 32x16 per pass, upper/bottom registers
// - only right operand sets pass count
// - narrow right operand one pass, full two
// - narrow issue each cycle, wide every other
// - stall back-to-back wide multiplies
// - operand size detected from values alone
// - divide one quotient bit per clock
// - early-in skips 23, 15 or 7 iterations
// - unit instruction during divide stalls pipeline
// - divide latency between 12 and 33 clocks
// - multiply result latencies 2/3, accumulate 1/2
// - divide repeat 11..32, latency 12..33 cycles
module pqu_core
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// issue from the integer pipeline
	input wire logic issue_valid,
	input wire pqu_pkg::pqu_op_t issue_op,
	input wire logic issue_signed,
	input wire logic [31:0] left_operand,
	input wire logic [31:0] right_operand,
	// interlock toward the integer pipeline
	output logic integer_pipeline_stall,
	// general-register multiply result
	output logic gpr_result_valid,
	output logic [31:0] gpr_result,
	// result words
	output logic [31:0] upper_result_word,
	output logic [31:0] bottom_result_word,
	output logic result_valid,
	output logic div_busy
);
	logic issue_take;
	logic right_wide;
	logic wide_busy_reg;
	logic [63:0] s2_prod_reg;
	logic s2_valid_reg;
	pqu_pkg::pqu_op_t s2_op_reg;
	logic wb_valid;
	pqu_pkg::pqu_op_t wb_op;
	logic [63:0] wb_prod;
	logic gpr_hold_valid_reg;
	logic [63:0] s1_prod_reg;
	logic s1_valid_reg;
	logic s1_wide_reg;
	logic s1_signed_reg;
	pqu_pkg::pqu_op_t s1_op_reg;
	logic [31:0] s1_mcand_reg;
	logic [15:0] s1_high_reg;
	logic [63:0] pass_lo;
	logic [63:0] full_prod;
	logic [63:0] acc_next;
	logic [31:0] gpr_hold_reg;
	pqu_pkg::pqu_div_state_t div_state_reg;
	logic [5:0] div_count_reg;
	logic [31:0] div_quot_reg;
	logic [32:0] div_rem_reg;
	logic [31:0] div_divisor_reg;
	logic div_neg_q_reg;
	logic div_neg_r_reg;
	logic [1:0] div_pad_reg;
	logic [5:0] skip_count;
	logic [31:0] dividend_mag;
	logic [31:0] divisor_mag;
	logic [32:0] rem_shift;
	logic [32:0] rem_try;

	////////////////////////////////////////////////////////////////////////
	// operand width detection and issue interlock
	// right operand fits the narrow width if its upper half is pure extension
	always_comb
	begin
		if (issue_signed)
			right_wide = (right_operand[31:15] != {17{1'b0}}) && (right_operand[31:15] != {17{1'b1}});
		else
			right_wide = right_operand[31:16] != 16'h0;
	end

	// stall on any op right behind a wide one, a divide behind a stage-one product, or any unit op while the divider runs
	always_comb
	begin
		integer_pipeline_stall = 1'b0;
		if (issue_valid && div_state_reg != pqu_pkg::PQU_ST_IDLE)
			integer_pipeline_stall = 1'b1;
		// the one array runs the second pass of a wide product this cycle,
		// so whatever comes right behind it waits one clock
		else if (issue_valid && wide_busy_reg)
			integer_pipeline_stall = 1'b1;
		else if (issue_valid && issue_op == pqu_pkg::PQU_OP_QUOTIENT && s1_valid_reg)
			integer_pipeline_stall = 1'b1;
	end
	assign issue_take = issue_valid && !integer_pipeline_stall;
	assign div_busy = div_state_reg != pqu_pkg::PQU_ST_IDLE;

	////////////////////////////////////////////////////////////////////////
	// multiply pipeline: pass one then optional second pass
	// one shared array: first pass takes the low half of the right operand,
	// second pass (cycle after a wide issue) takes the upper half
	pqu_booth_pass u_pass_lo
	(
		.multiplicand(wide_busy_reg ? s1_mcand_reg : left_operand),
		.multiplier_half(wide_busy_reg ? s1_high_reg : right_operand[15:0]),
		.signed_mult(wide_busy_reg ? s1_signed_reg : issue_signed),
		.signed_half(wide_busy_reg ? s1_signed_reg : (issue_signed && !right_wide)),
		.partial(pass_lo)
	);
	// upper-half pass weighs 2^16 against the first pass
	assign full_prod = s1_prod_reg + {pass_lo[47:0], 16'h0};

	// stage registers advance every cycle regardless of integer stalls
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_valid_reg <= 1'b0;
			s1_wide_reg <= 1'b0;
			s1_signed_reg <= 1'b0;
			s1_op_reg <= pqu_pkg::PQU_OP_WIDENING;
			s1_prod_reg <= 64'h0;
			s1_mcand_reg <= 32'h0;
			s1_high_reg <= 16'h0;
			wide_busy_reg <= 1'b0;
			s2_valid_reg <= 1'b0;
			s2_op_reg <= pqu_pkg::PQU_OP_WIDENING;
			s2_prod_reg <= 64'h0;
		end
		else
		begin
			s1_valid_reg <= issue_take && issue_op != pqu_pkg::PQU_OP_QUOTIENT;
			s1_wide_reg <= issue_take && right_wide;
			s1_signed_reg <= issue_signed;
			s1_op_reg <= issue_op;
			s1_prod_reg <= pass_lo;
			s1_mcand_reg <= left_operand;
			s1_high_reg <= right_operand[31:16];
			// second pass occupies the array next cycle
			wide_busy_reg <= issue_take && right_wide && issue_op != pqu_pkg::PQU_OP_QUOTIENT;
			// stage two only ever holds a finished wide product
			s2_valid_reg <= s1_valid_reg && s1_wide_reg;
			s2_op_reg <= s1_op_reg;
			s2_prod_reg <= full_prod;
		end
	end

	// narrow products retire from stage one, wide ones from stage two;
	// both can never be due at once since issue stalls behind a wide one
	always_comb
	begin
		wb_valid = 1'b0;
		wb_op = s1_op_reg;
		wb_prod = s1_prod_reg;
		if (s2_valid_reg)
		begin
			wb_valid = 1'b1;
			wb_op = s2_op_reg;
			wb_prod = s2_prod_reg;
		end
		else if (s1_valid_reg && !s1_wide_reg)
			wb_valid = 1'b1;
	end

	// accumulate or subtract into the result pair
	always_comb
	begin
		unique case (wb_op)
			pqu_pkg::PQU_OP_ACCUM: acc_next = {upper_result_word, bottom_result_word} + wb_prod;
			pqu_pkg::PQU_OP_SUBTRACT: acc_next = {upper_result_word, bottom_result_word} - wb_prod;
			default: acc_next = wb_prod;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// divider: early-in skip then one bit per clock
	always_comb
	begin
		dividend_mag = (issue_signed && left_operand[31]) ? 32'h0 - left_operand : left_operand;
		divisor_mag = (issue_signed && right_operand[31]) ? 32'h0 - right_operand : right_operand;
		if (dividend_mag[31:8] == 24'h0)
			skip_count = `PQU_SKIP_8;
		else if (dividend_mag[31:16] == 16'h0)
			skip_count = `PQU_SKIP_16;
		else if (dividend_mag[31:24] == 8'h0)
			skip_count = `PQU_SKIP_24;
		else
			skip_count = `PQU_DIV_SETUP;
		rem_shift = {div_rem_reg[31:0], div_quot_reg[31]};
		rem_try = rem_shift - {1'b0, div_divisor_reg};
	end

	// iterations left plus pad cycles plus one fix-up cycle give 12..33 clocks
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_state_reg <= pqu_pkg::PQU_ST_IDLE;
			div_count_reg <= 6'h00;
			div_quot_reg <= 32'h0;
			div_rem_reg <= 33'h0;
			div_divisor_reg <= 32'h0;
			div_neg_q_reg <= 1'b0;
			div_neg_r_reg <= 1'b0;
			div_pad_reg <= 2'h0;
		end
		else
		begin
			unique case (div_state_reg)
				pqu_pkg::PQU_ST_IDLE:
					if (issue_take && issue_op == pqu_pkg::PQU_OP_QUOTIENT)
					begin
						div_state_reg <= pqu_pkg::PQU_ST_DIV;
						div_count_reg <= `PQU_DIV_ITERS - skip_count;
						div_quot_reg <= dividend_mag << skip_count;
						div_rem_reg <= 33'h0;
						div_divisor_reg <= divisor_mag;
						div_neg_q_reg <= issue_signed && (left_operand[31] ^ right_operand[31]);
						div_neg_r_reg <= issue_signed && left_operand[31];
						// narrow dividends finish early but wait extra pad cycles in fix-up
						div_pad_reg <= skip_count[`PQU_PAD_HI:`PQU_PAD_LO];
					end
				pqu_pkg::PQU_ST_DIV:
				begin
					// one quotient bit per clock
					if (rem_try[32])
					begin
						div_rem_reg <= rem_shift;
						div_quot_reg <= {div_quot_reg[30:0], 1'b0};
					end
					else
					begin
						div_rem_reg <= rem_try;
						div_quot_reg <= {div_quot_reg[30:0], 1'b1};
					end
					div_count_reg <= div_count_reg - 6'h01;
					if (div_count_reg == 6'h01)
						div_state_reg <= pqu_pkg::PQU_ST_FIX;
				end
				pqu_pkg::PQU_ST_FIX:
				begin
					// pad cycles: 2 for 8-bit, 1 for 16-bit dividends
					div_pad_reg <= div_pad_reg - 2'h1;
					if (div_pad_reg == 2'h0)
						div_state_reg <= pqu_pkg::PQU_ST_IDLE;
				end
				default:
					div_state_reg <= pqu_pkg::PQU_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result words: multiply write-back and divide fix-up
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			upper_result_word <= 32'h0;
			bottom_result_word <= 32'h0;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= 1'b0;
			if (div_state_reg == pqu_pkg::PQU_ST_FIX && div_pad_reg == 2'h0)
			begin
				// sign fix applied after magnitude division
				bottom_result_word <= div_neg_q_reg ? 32'h0 - div_quot_reg : div_quot_reg;
				upper_result_word <= div_neg_r_reg ? 32'h0 - div_rem_reg[31:0] : div_rem_reg[31:0];
				result_valid <= 1'b1;
			end
			else if (wb_valid && wb_op != pqu_pkg::PQU_OP_GPR_MUL)
			begin
				{upper_result_word, bottom_result_word} <= acc_next;
				result_valid <= 1'b1;
			end
		end
	end

	// general-register multiply: one extra cycle of write-back
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gpr_result_valid <= 1'b0;
			gpr_result <= 32'h0;
			gpr_hold_reg <= 32'h0;
			gpr_hold_valid_reg <= 1'b0;
		end
		else
		begin
			// hold stage: narrow lands two cycles after issue, wide three
			gpr_hold_valid_reg <= wb_valid && wb_op == pqu_pkg::PQU_OP_GPR_MUL;
			gpr_hold_reg <= wb_prod[31:0];
			gpr_result_valid <= gpr_hold_valid_reg;
			gpr_result <= gpr_hold_reg;
		end
	end
endmodule

// ===== tb/pqu_core_assertions.sv
// timing checker of the product/quotient unit
`timescale 1ns/1ps
module pqu_core_assertions
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// issue
	input wire logic issue_valid,
	input wire pqu_pkg::pqu_op_t issue_op,
	input wire logic issue_signed,
	input wire logic [31:0] left_operand,
	input wire logic [31:0] right_operand,
	// answers
	input wire logic integer_pipeline_stall,
	input wire logic gpr_result_valid,
	input wire logic [31:0] gpr_result,
	input wire logic [31:0] upper_result_word,
	input wire logic [31:0] bottom_result_word,
	input wire logic result_valid,
	input wire logic div_busy
);
	logic take;
	logic mul;
	logic wide;
	logic prev_wide;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// width class taken from the operand value only
	assign take = issue_valid && !integer_pipeline_stall;
	assign mul = issue_op != pqu_pkg::PQU_OP_QUOTIENT;
	assign wide = issue_signed ? !(&right_operand[31:15] || !(|right_operand[31:15]))
		: |right_operand[31:16];
	// a wide product taken last edge still owns the array
	always_ff @(posedge clk)
		prev_wide <= take && mul && wide;
	property p_mul_ans;
		take && mul && !wide && issue_op != pqu_pkg::PQU_OP_GPR_MUL |-> ##2 result_valid;
	endproperty
	a_mul_ans: assert property (p_mul_ans) else $error("multiply answer late");
	property p_mul_wide;
		take && mul && wide && issue_op != pqu_pkg::PQU_OP_GPR_MUL
			|-> ##2 !result_valid ##1 result_valid;
	endproperty
	a_mul_wide: assert property (p_mul_wide) else $error("wide product timing");
	property p_gpr;
		take && issue_op == pqu_pkg::PQU_OP_GPR_MUL && !wide |-> ##3 gpr_result_valid;
	endproperty
	a_gpr: assert property (p_gpr) else $error("register product missing");
	property p_gpr_wide;
		take && issue_op == pqu_pkg::PQU_OP_GPR_MUL && wide |-> ##4 gpr_result_valid;
	endproperty
	a_gpr_wide: assert property (p_gpr_wide) else $error("wide register product late");
	property p_busy;
		take && !mul |=> div_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("divider not busy");
	property p_div_stall;
		div_busy && issue_valid |-> integer_pipeline_stall;
	endproperty
	a_div_stall: assert property (p_div_stall) else $error("issue during divide");
	property p_wide;
		take && mul && wide ##1 issue_valid && mul && wide |-> integer_pipeline_stall;
	endproperty
	a_wide: assert property (p_wide) else $error("wide pair not stalled");
	property p_narrow;
		issue_valid && mul && !wide && !div_busy && !prev_wide |-> !integer_pipeline_stall;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow product stalled");
	property p_div8;
		take && !mul && left_operand[31:7] == 25'h0
			|-> ##2 !result_valid [*8] ##1 !result_valid [*3] ##1 result_valid;
	endproperty
	a_div8: assert property (p_div8) else $error("short divide timing");
	property p_div32;
		take && !mul && !issue_signed && left_operand[31] |-> ##34 result_valid;
	endproperty
	a_div32: assert property (p_div32) else $error("long divide timing");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pqu_core pqu_core_assertions i_chk(.clk(clk), .resetn(resetn),
	.issue_valid(issue_valid), .issue_op(issue_op), .issue_signed(issue_signed),
	.left_operand(left_operand), .right_operand(right_operand),
	.integer_pipeline_stall(integer_pipeline_stall), .gpr_result_valid(gpr_result_valid),
	.gpr_result(gpr_result), .upper_result_word(upper_result_word),
	.bottom_result_word(bottom_result_word), .result_valid(result_valid),
	.div_busy(div_busy));

// ===== tb/pqu_int_pipe.sv
// integer pipeline model offering queued instructions
`timescale 1ns/1ps
module pqu_int_pipe
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// interlock
	input wire logic integer_pipeline_stall,
	// issue
	output logic issue_valid,
	output pqu_pkg::pqu_op_t issue_op,
	output logic issue_signed,
	output logic [31:0] left_operand,
	output logic [31:0] right_operand
);
	logic [67:0] q[$];
	logic [67:0] w;
	task automatic push(input logic [67:0] c);
		q.push_back(c);
	endtask
	// offer held until taken; idle operands flip so stale data is never trusted
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			issue_valid <= 1'b0;
			issue_op <= pqu_pkg::PQU_OP_WIDENING;
			issue_signed <= 1'b0;
			left_operand <= 32'h0;
			right_operand <= 32'h0;
		end
		else if (!issue_valid || !integer_pipeline_stall)
		begin
			if (q.size() > 0)
			begin
				w = q.pop_front();
				issue_valid <= 1'b1;
				issue_op <= pqu_pkg::pqu_op_t'(w[67:65]);
				issue_signed <= w[64];
				left_operand <= w[63:32];
				right_operand <= w[31:0];
			end
			else
			begin
				issue_valid <= 1'b0;
				left_operand <= ~left_operand;
				right_operand <= ~right_operand;
			end
		end
	end
endmodule

// ===== tb/tb_multiply_divide_unit.sv
// self-checking bench of the product/quotient unit
`timescale 1ns/1ps
module tb_multiply_divide_unit;
	typedef struct packed {logic [2:0] op; logic sg; logic [31:0] l, r, hi, lo;} pqu_row_t;
	logic clk;
	logic resetn = 1'b1;
	logic issue_valid;
	pqu_pkg::pqu_op_t issue_op;
	logic issue_signed;
	logic [31:0] left_operand;
	logic [31:0] right_operand;
	logic integer_pipeline_stall;
	logic gpr_result_valid;
	logic [31:0] gpr_result;
	logic [31:0] upper_result_word;
	logic [31:0] bottom_result_word;
	logic result_valid;
	logic div_busy;
	int n_fail = 0;
	int checks = 0;
	int k;
	// op, signed, left, right, upper, bottom
	pqu_row_t rows [9] = '{'{3'h0, 1'b0, 32'h3, 32'h5, 32'h0, 32'hF},
		'{3'h1, 1'b0, 32'h2, 32'h4, 32'h0, 32'h17},
		'{3'h2, 1'b0, 32'h1, 32'h3, 32'h0, 32'h14},
		'{3'h0, 1'b1, 32'hFFFFFFFF, 32'h12345, 32'hFFFFFFFF, 32'hFFFEDCBB},
		'{3'h3, 1'b0, 32'h64, 32'h7, 32'h2, 32'hE},
		'{3'h3, 1'b1, 32'hFFFFFF9C, 32'h7, 32'hFFFFFFFE, 32'hFFFFFFF2},
		'{3'h3, 1'b0, 32'h12345, 32'h10, 32'h5, 32'h1234},
		'{3'h3, 1'b0, 32'h80000000, 32'h3, 32'h2, 32'h2AAAAAAA},
		'{3'h4, 1'b0, 32'h6, 32'h7, 32'h0, 32'h2A}};
	pqu_core i_dut(.clk(clk), .resetn(resetn), .issue_valid(issue_valid),
		.issue_op(issue_op), .issue_signed(issue_signed), .left_operand(left_operand),
		.right_operand(right_operand), .integer_pipeline_stall(integer_pipeline_stall),
		.gpr_result_valid(gpr_result_valid), .gpr_result(gpr_result),
		.upper_result_word(upper_result_word), .bottom_result_word(bottom_result_word),
		.result_valid(result_valid), .div_busy(div_busy));
	pqu_int_pipe i_pipe(.clk(clk), .resetn(resetn),
		.integer_pipeline_stall(integer_pipeline_stall), .issue_valid(issue_valid),
		.issue_op(issue_op), .issue_signed(issue_signed), .left_operand(left_operand),
		.right_operand(right_operand));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait for either answer pulse
	task automatic wait_res();
		int t;
		for (t = 0; t < 60; t++)
		begin
			@(posedge clk);
			#1;
			if (result_valid === 1'b1 || gpr_result_valid === 1'b1)
				break;
		end
		if (t == 60)
		begin
			n_fail++;
			test_done();
		end
	endtask
	task automatic count_stall(input int n, output int c);
		c = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			if (issue_valid === 1'b1 && integer_pipeline_stall === 1'b1)
				c++;
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		chk("reset words", upper_result_word | bottom_result_word, 32'h0);
		@(posedge clk);
		resetn <= 1'b1;
		foreach (rows[j])
		begin
			i_pipe.push({rows[j].op, rows[j].sg, rows[j].l, rows[j].r});
			wait_res();
			if (rows[j].op == 3'h4)
				chk("gpr", gpr_result, rows[j].lo);
			else
			begin
				chk("upper", upper_result_word, rows[j].hi);
				chk("bottom", bottom_result_word, rows[j].lo);
			end
		end
		// back-to-back wide products: one stall only
		repeat (2) i_pipe.push({4'h0, 32'h10000, 32'h10000});
		count_stall(6, k);
		chk("wide stalls", k, 32'h1);
		repeat (3) i_pipe.push({4'h0, 32'h2, 32'h3});
		count_stall(6, k);
		chk("narrow stalls", k, 32'h0);
		chk("narrow bottom", bottom_result_word, 32'h6);
		// a product queued behind a long divide waits it out
		i_pipe.push({4'h6, 32'h80000000, 32'h3});
		i_pipe.push({4'h0, 32'h3, 32'h5});
		count_stall(44, k);
		chk("divide stall", {31'h0, k >= 32}, 32'h1);
		chk("after divide", bottom_result_word, 32'hF);
		// reset in mid divide
		i_pipe.push({4'h6, 32'h80000000, 32'h3});
		repeat (5) @(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		#1;
		chk("busy cleared", {31'h0, div_busy}, 32'h0);
		test_done();
	end
endmodule
